// ===== logic/aux_seq_regs_pkg.sv
// Register map constants for the auxiliary converter last-step bank
`default_nettype none
package aux_seq_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Printed offsets are register indices; byte address is four times each
  localparam logic [ADDR_W-1:0] IDX_STEP15_CFG = 8'h9f;
  localparam logic [ADDR_W-1:0] IDX_SPARE_A = 8'ha0;
  localparam logic [ADDR_W-1:0] IDX_SPARE_B = 8'ha1;
  localparam int BYTE_ADDR_W = 10;

  localparam logic [REG_W-1:0] STEP15_RESET = 16'h000f;
  localparam logic [REG_W-1:0] SPARE_A_RESET = 16'h0210;
  localparam logic [REG_W-1:0] SPARE_B_RESET = 16'h0000;

  // Writable masks; the rest reads as the reset constant
  localparam logic [REG_W-1:0] STEP15_WMASK = 16'he01f;
  localparam logic [REG_W-1:0] SPARE_A_WMASK = 16'h0c30;
  localparam logic [REG_W-1:0] SPARE_B_WMASK = 16'hffff;

  localparam int EN_BIT = 15;
  localparam int GAIN_HI = 14;
  localparam int GAIN_LO = 13;
  localparam int NEG_BIT = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 0;

  // Gain codes
  localparam logic [1:0] GAIN_X1 = 2'h0;
  localparam logic [1:0] GAIN_X2 = 2'h1;

  // Decoded gain values
  localparam logic [2:0] GAIN_VAL_1 = 3'h1;
  localparam logic [2:0] GAIN_VAL_2 = 3'h2;
  localparam logic [2:0] GAIN_VAL_4 = 3'h4;

  // Negative input selections
  localparam logic [1:0] NEG_GROUND = 2'h0;
  localparam logic [1:0] NEG_INPUT7 = 2'h1;
  localparam logic [1:0] NEG_AUTO = 2'h2;

  // Positive input codes
  localparam logic [3:0] POS_TEMP_SENSOR = 4'h8;
  localparam logic [3:0] POS_INT_SHORT = 4'h9;
  localparam logic [3:0] POS_TEST_DAC = 4'ha;
  localparam logic [3:0] POS_ANALOG_SUPPLY = 4'hb;
  localparam logic [3:0] POS_IO_SUPPLY = 4'hc;
  localparam logic [3:0] POS_DIGITAL_SUPPLY = 4'hd;
  localparam logic [3:0] POS_ANALOG_POWER = 4'he;
  localparam logic [3:0] POS_DIGITAL_POWER = 4'hf;
  localparam int POS_INTERNAL_BIT = 3;
endpackage
`default_nettype wire

// ===== logic/aux_seq_step_regs.sv
// Last sequencer step configuration and spare registers, Avalon-MM slave
//
// Local design decision: the Avalon-MM slave port.
`default_nettype none
module aux_seq_step_regs
  import aux_seq_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [BYTE_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  output logic last_step_enable,
  output logic [2:0] last_step_gain,
  output logic [1:0] last_step_neg_input,
  output logic [3:0] last_step_pos_input,
  output logic last_step_pos_internal
);

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait cycle per access: request taken while ack_ff is low,
  // waitrequest low in the next cycle, then back high, so two
  // accesses never overlap.
  logic ack_ff;
  logic nxt_ack;
  logic wait_ff;
  logic nxt_wait;
  logic [ADDR_W-1:0] idx;
  logic word_ok;
  logic req;

  assign idx = address[BYTE_ADDR_W-1:2];
  assign word_ok = (address[1:0] == 2'h0);
  assign req = (read | write) & ~ack_ff;

  always_comb begin
    nxt_ack = req;
    nxt_wait = ~req;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
    end else begin
      ack_ff <= nxt_ack;
      wait_ff <= nxt_wait;
    end
  end

  assign waitrequest = wait_ff;

  // ---------------------------------------------------------------
  // Register words
  // ---------------------------------------------------------------
  // Commit only while the answer stands: the master still holds
  // address and data, and sees waitrequest low at this very edge.
  logic commit_wr;
  logic [REG_W-1:0] lane_mask;
  logic hit_step;
  logic hit_spare_a;
  logic hit_spare_b;
  logic step_wr;
  logic spare_a_wr;
  logic spare_b_wr;
  logic [REG_W-1:0] step_word;
  logic [REG_W-1:0] spare_a_word;
  logic [REG_W-1:0] spare_b_word;

  assign commit_wr = write & ack_ff & word_ok;
  assign lane_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign hit_step = (idx == IDX_STEP15_CFG);
  assign hit_spare_a = (idx == IDX_SPARE_A);
  assign hit_spare_b = (idx == IDX_SPARE_B);
  assign step_wr = commit_wr & hit_step;
  assign spare_a_wr = commit_wr & hit_spare_a;
  assign spare_b_wr = commit_wr & hit_spare_b;

  // Only the writable bits change; reserved bits keep the reset value
  masked_word_reg #(
    .RESET_VAL(STEP15_RESET),
    .WRITE_MASK(STEP15_WMASK)
  ) step_reg (
    .clk(clk),
    .rst_b(rst_b),
    .commit(step_wr),
    .wdata(writedata[REG_W-1:0]),
    .lane_mask(lane_mask),
    .value(step_word)
  );

  // Spare words exist for the register-map check only
  masked_word_reg #(
    .RESET_VAL(SPARE_A_RESET),
    .WRITE_MASK(SPARE_A_WMASK)
  ) spare_a_reg (
    .clk(clk),
    .rst_b(rst_b),
    .commit(spare_a_wr),
    .wdata(writedata[REG_W-1:0]),
    .lane_mask(lane_mask),
    .value(spare_a_word)
  );

  // Fully writable spare word
  masked_word_reg #(
    .RESET_VAL(SPARE_B_RESET),
    .WRITE_MASK(SPARE_B_WMASK)
  ) spare_b_reg (
    .clk(clk),
    .rst_b(rst_b),
    .commit(spare_b_wr),
    .wdata(writedata[REG_W-1:0]),
    .lane_mask(lane_mask),
    .value(spare_b_word)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Data and status are latched at the taking edge and stand
  // through the cycle in which waitrequest is low.
  logic [DATA_W-1:0] readdata_ff;
  logic [DATA_W-1:0] nxt_readdata;
  logic [1:0] response_ff;
  logic [1:0] nxt_response;
  logic [REG_W-1:0] step_rd;
  logic [REG_W-1:0] spare_a_rd;

  // Reserved fields read as their fixed constants
  assign step_rd = (step_word & STEP15_WMASK) |
                   (STEP15_RESET & ~STEP15_WMASK);
  assign spare_a_rd = (spare_a_word & SPARE_A_WMASK) |
                      (SPARE_A_RESET & ~SPARE_A_WMASK);

  always_comb begin
    nxt_readdata = readdata_ff;
    nxt_response = response_ff;
    if (req) begin
      nxt_readdata = '0;
      nxt_response = 2'h0;
      // Misaligned or unmapped words answer with an error
      if (!word_ok) begin
        nxt_response = 2'h2;
      end else begin
        case (idx)
          IDX_STEP15_CFG: begin
            nxt_readdata = {16'h0000, step_rd};
          end
          IDX_SPARE_A: begin
            nxt_readdata = {16'h0000, spare_a_rd};
          end
          IDX_SPARE_B: begin
            nxt_readdata = {16'h0000, spare_b_word};
          end
          default: begin
            nxt_response = 2'h2;
          end
        endcase
      end
      // Writes return zero data; only the status matters
      if (!read) begin
        nxt_readdata = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_ff <= '0;
      response_ff <= 2'h0;
    end else begin
      readdata_ff <= nxt_readdata;
      response_ff <= nxt_response;
    end
  end

  assign readdata = readdata_ff;
  assign response = response_ff;

  // ---------------------------------------------------------------
  // Step decode to the converter mux
  // ---------------------------------------------------------------
  // Spare registers feed nothing here: they only reach the read path.
  logic en_ff;
  logic nxt_en;
  logic [2:0] gain_ff;
  logic [2:0] nxt_gain;
  logic [1:0] neg_ff;
  logic [1:0] nxt_neg;
  logic [3:0] pos_ff;
  logic [3:0] nxt_pos;
  logic internal_ff;
  logic nxt_internal;
  logic [3:0] pos_code;

  // Decoded copies lag the register word by one cycle
  assign pos_code = step_word[POS_HI:POS_LO];

  always_comb begin
    nxt_en = step_word[EN_BIT];
    case (step_word[GAIN_HI:GAIN_LO])
      GAIN_X1: nxt_gain = GAIN_VAL_1;
      GAIN_X2: nxt_gain = GAIN_VAL_2;
      default: nxt_gain = GAIN_VAL_4;
    endcase
    nxt_pos = pos_code;
    nxt_internal = pos_code[POS_INTERNAL_BIT];
    if (pos_code[POS_INTERNAL_BIT]) begin
      nxt_neg = NEG_AUTO;
    end else if (step_word[NEG_BIT]) begin
      nxt_neg = NEG_INPUT7;
    end else begin
      nxt_neg = NEG_GROUND;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= 1'b0;
      gain_ff <= GAIN_VAL_1;
      neg_ff <= NEG_AUTO;
      pos_ff <= POS_DIGITAL_POWER;
      internal_ff <= 1'b1;
    end else begin
      en_ff <= nxt_en;
      gain_ff <= nxt_gain;
      neg_ff <= nxt_neg;
      pos_ff <= nxt_pos;
      internal_ff <= nxt_internal;
    end
  end

  assign last_step_enable = en_ff;
  assign last_step_gain = gain_ff;
  assign last_step_neg_input = neg_ff;
  assign last_step_pos_input = pos_ff;
  assign last_step_pos_internal = internal_ff;

endmodule // aux_seq_step_regs

// ---------------------------------------------------------------
// One register word with per-bit write mask and byte lanes
// ---------------------------------------------------------------
// Bits outside WRITE_MASK never leave RESET_VAL, so reserved
// fields need no storage of their own beyond the constant.
module masked_word_reg
  import aux_seq_regs_pkg::*;
#(
  parameter logic [REG_W-1:0] RESET_VAL = 16'h0000,
  parameter logic [REG_W-1:0] WRITE_MASK = 16'hffff
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic commit,
  input wire logic [REG_W-1:0] wdata,
  input wire logic [REG_W-1:0] lane_mask,
  output logic [REG_W-1:0] value
);

  logic [REG_W-1:0] word_ff;
  logic [REG_W-1:0] nxt_word;
  logic [REG_W-1:0] bit_mask;

  // Field mask and byte lanes combine bit by bit
  assign bit_mask = WRITE_MASK & lane_mask;

  always_comb begin
    nxt_word = word_ff;
    if (commit) begin
      nxt_word = (word_ff & ~bit_mask) | (wdata & bit_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_ff <= RESET_VAL;
    end else begin
      word_ff <= nxt_word;
    end
  end

  assign value = word_ff;

endmodule // masked_word_reg
`default_nettype wire

// ===== tb/aux_seq_step_regs_chk.sv
// Port assertions for the last-step register bank
`default_nettype none
module aux_seq_step_regs_chk
  import aux_seq_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [BYTE_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  input wire logic last_step_enable,
  input wire logic [2:0] last_step_gain,
  input wire logic [1:0] last_step_neg_input,
  input wire logic [3:0] last_step_pos_input,
  input wire logic last_step_pos_internal
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_ack;
    !waitrequest;
  endsequence
  sequence s_step_wr;
    s_ack and (write && address == 10'h27c && byteenable[1:0] == 2'h3);
  endsequence
  chk_ack_one: assert property ((read || write) && waitrequest |=> s_ack)
    else $error("ack late");
  chk_ack_short: assert property (s_ack |=> waitrequest)
    else $error("ack too long");
  chk_step_rsvd: assert property (
    s_ack and (read && address == 10'h27c) |-> readdata[12:5] == 8'h0)
    else $error("step reserved bits");
  chk_spare_rsvd: assert property (
    s_ack and (read && address == 10'h280) |->
    {readdata[15:12], readdata[9:6], readdata[3:0]} == 12'h080)
    else $error("spare reserved bits");
  chk_step_upd: assert property (s_step_wr |-> ##2
    {last_step_enable, last_step_pos_input} == $past({writedata[15],
    writedata[3:0]}, 2)) else $error("step fields");
  chk_gain_four: assert property (
    s_step_wr and writedata[14] |-> ##2 last_step_gain == 3'h4)
    else $error("gain four");
  chk_neg_manual: assert property (
    s_step_wr and !writedata[3] |-> ##2
    last_step_neg_input == {1'b0, $past(writedata[4], 2)})
    else $error("neg input");
  chk_neg_auto: assert property (
    last_step_pos_internal |-> last_step_neg_input == 2'h2)
    else $error("neg auto");
endmodule // aux_seq_step_regs_chk
bind aux_seq_step_regs aux_seq_step_regs_chk u_chk (.clk, .rst_b, .address,
  .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
  .response, .last_step_enable, .last_step_gain, .last_step_neg_input,
  .last_step_pos_input, .last_step_pos_internal);
`default_nettype wire

// ===== tb/host_master.sv
// Avalon master standing in for host software
`default_nettype none
module host_master
  import aux_seq_regs_pkg::*;
(
  input wire logic clk,
  output logic [BYTE_ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [DATA_W-1:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {address, read, write, writedata, byteenable} = '0;
  end
  task automatic xfer(input logic wr, input logic [9:0] a,
    input logic [31:0] d, input logic [3:0] be,
    output logic [31:0] rd, output logic [1:0] rs);
    @(posedge clk);
    {write, read} <= {wr, !wr};
    {address, writedata, byteenable} <= {a, d, be};
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    rs = response;
    {write, read} <= 2'b00;
    // Released lines show garbage, not the last value
    {address, writedata} <= ~{a, d};
  endtask
endmodule // host_master
`default_nettype wire

// ===== tb/tb_aux_seq_step_regs.sv
// Self-checking bench for the last-step register bank
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_aux_seq_step_regs
  import aux_seq_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst_b = 0;
  logic read, write, waitrequest, last_step_enable, last_step_pos_internal;
  logic [9:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable, last_step_pos_input;
  logic [1:0] response, last_step_neg_input, rs;
  logic [2:0] last_step_gain;
  logic [10:0] outs;
  int error_cnt = 0;
  int compares = 0;
  int m[3] = '{16'h000f, 16'h0210, 16'h0000};
  int wm[3] = '{STEP15_WMASK, SPARE_A_WMASK, SPARE_B_WMASK};
  assign outs = {last_step_enable, last_step_gain, last_step_neg_input,
    last_step_pos_input, last_step_pos_internal};
  always #20 clk = ~clk;
  aux_seq_step_regs dut (.clk, .rst_b, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .response, .last_step_enable,
    .last_step_gain, .last_step_neg_input, .last_step_pos_input,
    .last_step_pos_internal);
  host_master host (.clk, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .response);
  function automatic logic [10:0] dec(int v);
    return {v[15], v[14] ? 3'h4 : v[13] ? 3'h2 : 3'h1,
      v[3] ? 2'h2 : {1'b0, v[4]}, v[3:0], v[3]};
  endfunction
  task conclude;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    int a, k;
    logic ok, wr;
    logic [31:0] d, lm;
    logic [3:0] be;
    a = $urandom(32'h3e73);
    repeat (12) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    `CHK(outs, dec(m[0]))
    for (int i = 0; i < 90; i++) begin
      k = i < 3 ? i : $urandom % 4;
      a = k < 3 ? 10'h27c + 4 * k : $urandom % 1024;
      wr = i >= 3 && $urandom % 2;
      d = $urandom;
      be = $urandom % 2 ? 4'hf : $urandom;
      if (i >= 3 && i < 19) begin
        {a, wr, be} = {32'h27c, 1'b1, 4'hf};
        {d[14:13], d[3:0]} = {i[1:0], i[3:0] + 4'hd};
      end
      host.xfer(wr, a[9:0], d, be, rd, rs);
      ok = a[1:0] == 0 && a[9:2] >= 8'h9f && a[9:2] <= 8'ha1;
      k = a[9:2] - 8'h9f;
      lm = {{8{be[1]}}, {8{be[0]}}};
      `CHK(rs, ok ? 2'h0 : 2'h2)
      if (wr && ok) m[k] = m[k] & ~(wm[k] & lm) | d & wm[k] & lm;
      if (!wr) `CHK(rd, ok ? m[k] : 0)
      repeat (2) @(posedge clk);
      `CHK(outs, dec(m[0]))
    end
    conclude();
  end
  // Watchdog, over five times the expected run
  initial begin
    repeat (2500) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule // tb_aux_seq_step_regs
`default_nettype wire
